// >>> hdl/conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module conv_timer
  import thermal_alarm_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CONV_CYCLES,
  parameter int EXTRA_CYCLES = CANCEL_EXTRA_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic start,
  input wire logic long_conv,
  // Result
  output logic done
);

  logic [31:0] count_r;
  logic busy_r;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_r <= 32'h0;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        count_r <= long_conv ? 32'(BASE_CYCLES + EXTRA_CYCLES - 1) : 32'(BASE_CYCLES - 1);
      end else if (busy_r) begin
        if (count_r == 32'h0) begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end else begin
          count_r <= count_r - 32'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> hdl/thermal_alarm_status_mask.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_status_mask
  import thermal_alarm_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_CONV_CYCLES,
  parameter int EXTRA_CYCLES = CANCEL_EXTRA_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port from the bus engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Conversion engine
  output logic conv_start,
  output logic [2:0] conv_chan,
  output logic conv_cancel,
  input wire logic [7:0] meas_temp,
  input wire logic meas_fault,
  // Thresholds, one byte per channel
  input wire logic [55:0] warn_limits,
  input wire logic [47:0] overheat_limits,
  // Open-drain alarm pins, active low
  output logic warning_alarm_o,
  output logic warning_alarm_oe,
  output logic overheat_shutdown_output_o,
  output logic overheat_shutdown_output_oe
);

  logic [7:0] config1_r;
  logic [7:0] config2_r;
  logic [7:0] overheat_channel_mask_r;
  logic por_req_r;
  logic soft_rst;
  seq_e seq_r;
  logic [2:0] cur_ch_r;
  logic [6:0] fault_r;
  logic [6:0] warn_cond_r;
  logic [6:0] warn_flag_r;
  logic [5:0] ovh_cond;
  logic [5:0] ovh_flag;
  logic [7:0] warning_flag_status;
  logic [7:0] overheat_status;
  logic [7:0] fault_status;
  logic conv_done;
  logic sample;
  logic rd_status1;
  logic rd_status2;
  logic [2:0] next_ch;

  // The self-clearing power-on bit returns every register here to its reset state.
  assign soft_rst = !reset_n || por_req_r;
  assign rd_status1 = reg_rd && (reg_addr == ADDR_STATUS1);
  assign rd_status2 = reg_rd && (reg_addr == ADDR_STATUS2);
  assign sample = conv_done && (seq_r == SEQ_CONV);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      por_req_r <= 1'b0;
    end else begin
      por_req_r <= reg_wr && (reg_addr == ADDR_CONFIG1) && reg_wdata[CFG1_POR_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (soft_rst) begin
      config1_r <= REG_RESET;
      config2_r <= REG_RESET;
      overheat_channel_mask_r <= REG_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CONFIG1: config1_r <= reg_wdata & CONFIG1_WMASK;
        ADDR_CONFIG2: config2_r <= reg_wdata & CONFIG2_WMASK;
        ADDR_CONFIG3: overheat_channel_mask_r <= reg_wdata & OVERHEAT_CH_MASK;
        default: ;
      endcase
    end
  end

  // Next channel after the current one, skipping remotes that showed a diode fault.
  function automatic logic [2:0] pick_next(input logic [2:0] cur, input logic [6:0] skip);
    int k;
    int cand;
    logic found;
    logic [2:0] res;
    res = CH_LOCAL;
    found = 1'b0;
    for (k = 1; k <= NUM_CH; k++) begin
      cand = (int'(cur) + k) % NUM_CH;
      if (!found && !skip[cand]) begin
        res = 3'(cand);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  assign next_ch = pick_next(cur_ch_r, fault_r);

  // Standby only takes effect between conversions so a result is never cut short.
  always_ff @(posedge clk_sys) begin
    if (soft_rst) begin
      seq_r <= SEQ_IDLE;
      cur_ch_r <= CH_LOCAL;
      conv_start <= 1'b0;
      conv_chan <= CH_LOCAL;
      conv_cancel <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      unique case (seq_r)
        SEQ_IDLE: begin
          if (!config1_r[CFG1_STOP_BIT]) begin
            seq_r <= SEQ_CONV;
            conv_start <= 1'b1;
            conv_chan <= cur_ch_r;
            conv_cancel <= (cur_ch_r == CH_REMOTE1) && config1_r[CFG1_CANCEL_BIT];
          end
        end
        SEQ_CONV: begin
          if (conv_done) begin
            seq_r <= SEQ_IDLE;
            cur_ch_r <= next_ch;
          end
        end
      endcase
    end
  end

  conv_timer #(
    .BASE_CYCLES(BASE_CYCLES),
    .EXTRA_CYCLES(EXTRA_CYCLES)
  ) u_conv_timer (
    .clk_sys(clk_sys),
    .reset_n(!soft_rst),
    .start(conv_start),
    .long_conv(conv_cancel),
    .done(conv_done)
  );

  // Fault bits stay set until reset, so a skipped channel is not retried.
  always_ff @(posedge clk_sys) begin
    if (soft_rst) begin
      fault_r <= 7'h00;
    end else if (sample && meas_fault && (cur_ch_r != CH_LOCAL)) begin
      fault_r[cur_ch_r] <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_warn
      logic signed [TEMP_W:0] lim;
      logic signed [TEMP_W:0] tmp;
      logic hit;
      logic above;
      logic below;
      // Both sides are sign-extended by one bit so the limit minus hysteresis cannot wrap.
      assign lim = {warn_limits[gi*TEMP_W + TEMP_W - 1], warn_limits[gi*TEMP_W +: TEMP_W]};
      assign tmp = {meas_temp[TEMP_W-1], meas_temp};
      assign hit = sample && !meas_fault && (cur_ch_r == 3'(gi));
      assign above = $signed(meas_temp) > $signed(lim[TEMP_W-1:0]);
      assign below = $signed(tmp) < $signed(lim) - HYSTERESIS_DEGC;
      always_ff @(posedge clk_sys) begin
        if (soft_rst) begin
          warn_cond_r[gi] <= 1'b0;
        end else if (hit) begin
          if (above) begin
            warn_cond_r[gi] <= 1'b1;
          end else if (below) begin
            warn_cond_r[gi] <= 1'b0;
          end
        end
      end
      // A set at conversion end wins over a read that clears in the same cycle.
      always_ff @(posedge clk_sys) begin
        if (soft_rst) begin
          warn_flag_r[gi] <= 1'b0;
        end else if (hit && (above || (warn_cond_r[gi] && !below))) begin
          warn_flag_r[gi] <= 1'b1;
        end else if (rd_status1) begin
          warn_flag_r[gi] <= 1'b0;
        end
      end
    end

    for (gi = 1; gi < NUM_CH; gi++) begin : g_ovh
      if (OVERHEAT_CH_MASK[gi-1]) begin : g_on
        logic signed [TEMP_W:0] lim;
        logic signed [TEMP_W:0] tmp;
        logic hit;
        logic above;
        logic below;
        logic cond_r;
        logic flag_r;
        assign lim = {overheat_limits[(gi-1)*TEMP_W + TEMP_W - 1],
                      overheat_limits[(gi-1)*TEMP_W +: TEMP_W]};
        assign tmp = {meas_temp[TEMP_W-1], meas_temp};
        assign hit = sample && !meas_fault && (cur_ch_r == 3'(gi));
        assign above = $signed(meas_temp) > $signed(lim[TEMP_W-1:0]);
        assign below = $signed(tmp) < $signed(lim) - HYSTERESIS_DEGC;
        always_ff @(posedge clk_sys) begin
          if (soft_rst) begin
            cond_r <= 1'b0;
          end else if (hit && above) begin
            cond_r <= 1'b1;
          end else if (hit && below) begin
            cond_r <= 1'b0;
          end
        end
        always_ff @(posedge clk_sys) begin
          if (soft_rst) begin
            flag_r <= 1'b0;
          end else if (hit && (above || (cond_r && !below))) begin
            flag_r <= 1'b1;
          end else if (rd_status2) begin
            flag_r <= 1'b0;
          end
        end
        assign ovh_cond[gi-1] = cond_r;
        assign ovh_flag[gi-1] = flag_r;
      end else begin : g_off
        assign ovh_cond[gi-1] = 1'b0;
        assign ovh_flag[gi-1] = 1'b0;
      end
    end
  endgenerate

  assign warning_flag_status = {1'b0, warn_flag_r[CH_LOCAL], warn_flag_r[6:1]};
  assign overheat_status = {2'b00, ovh_flag};
  assign fault_status = {1'b0, fault_r[6:1], 1'b0};

  always_ff @(posedge clk_sys) begin
    if (soft_rst) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CONFIG1: reg_rdata <= config1_r;
        ADDR_CONFIG2: reg_rdata <= config2_r;
        ADDR_CONFIG3: reg_rdata <= overheat_channel_mask_r;
        ADDR_STATUS1: reg_rdata <= warning_flag_status;
        ADDR_STATUS2: reg_rdata <= overheat_status;
        ADDR_STATUS3: reg_rdata <= fault_status;
        default: reg_rdata <= REG_RESET;
      endcase
    end
  end

  // Both pins only ever pull low; the enable carries the alarm.
  always_ff @(posedge clk_sys) begin
    if (soft_rst) begin
      warning_alarm_o <= 1'b0;
      warning_alarm_oe <= 1'b0;
      overheat_shutdown_output_o <= 1'b0;
      overheat_shutdown_output_oe <= 1'b0;
    end else begin
      warning_alarm_o <= 1'b0;
      overheat_shutdown_output_o <= 1'b0;
      warning_alarm_oe <= |(warning_flag_status & ~config2_r);
      // Driven from the condition, not the flags, so a status read leaves it set.
      overheat_shutdown_output_oe <= |(ovh_cond & ~overheat_channel_mask_r[5:0]);
    end
  end

endmodule
`default_nettype wire

// >>> include/thermal_alarm_pkg.sv
// Operation
// - Overheat channel mask bits 5,4,3,0 keep channels 6,5,4,1 off the overheat output.
// - Warning flag status bit 6 sets when local temperature exceeds its warning limit.
// - Warning flag status bits 5..0 set when remotes 6..1 exceed their warning limits.
// - Series-resistance cancellation applies to channel 1 only, when config-1 bit 3 is set.
// - Cancellation lengthens the channel-1 conversion by 125 ms.
// - Open or supply-tied remote diodes report a fault and are skipped in sequence.
// - Reading status 2 alone clears overheat flags; the overheat output stays.
// - An alarm condition ends only below the limit minus 4 degrees C.
// - A warning cleared while its condition persists returns at that channel's next conversion end.
package thermal_alarm_pkg;

  localparam int NUM_CH = 7;
  localparam logic [2:0] CH_LOCAL = 3'h0;
  localparam logic [2:0] CH_REMOTE1 = 3'h1;

  localparam logic [7:0] ADDR_CONFIG1 = 8'h41;
  localparam logic [7:0] ADDR_CONFIG2 = 8'h42;
  localparam logic [7:0] ADDR_CONFIG3 = 8'h43;
  localparam logic [7:0] ADDR_STATUS1 = 8'h44;
  localparam logic [7:0] ADDR_STATUS2 = 8'h45;
  localparam logic [7:0] ADDR_STATUS3 = 8'h46;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CONFIG1_WMASK = 8'hB8;
  localparam logic [7:0] CONFIG2_WMASK = 8'h7F;
  localparam logic [7:0] OVERHEAT_CH_MASK = 8'h39;
  localparam int CFG1_STOP_BIT = 7;
  localparam int CFG1_POR_BIT = 6;
  localparam int CFG1_CANCEL_BIT = 3;

  localparam int TEMP_W = 8;
  localparam logic signed [TEMP_W:0] HYSTERESIS_DEGC = 9'sh004;

  localparam int CLK_MHZ = 200;
  localparam int CANCEL_EXTRA_MS = 125;
  localparam int CANCEL_EXTRA_CYCLES = CANCEL_EXTRA_MS * CLK_MHZ * 1000;
  localparam int BASE_CONV_CYCLES = 1000;

  typedef enum logic {SEQ_IDLE, SEQ_CONV} seq_e;

endpackage

// >>> tb/conv_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_engine_model #(
  parameter int BASE_CYCLES = 10,
  parameter int EXTRA_CYCLES = 20
) (
  // Clock and conversion request
  input wire logic clk_sys,
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire logic conv_cancel,
  // Scene set by the bench
  input wire logic [55:0] temps,
  input wire logic [6:0] faults,
  // Result
  output logic [7:0] meas_temp,
  output logic meas_fault
);
  int cnt_r = 1000000;
  always_ff @(posedge clk_sys) begin
    cnt_r <= conv_start ? 0 : cnt_r + 1;
  end
  // Outside the result window the lines toggle, so a mistimed sample reads garbage.
  always_comb begin
    if (cnt_r <= BASE_CYCLES + (conv_cancel ? EXTRA_CYCLES : 0)) begin
      meas_temp = temps[conv_chan * 8 +: 8];
      meas_fault = faults[conv_chan];
    end else begin
      meas_temp = cnt_r[7:0];
      meas_fault = cnt_r[0];
    end
  end
endmodule
`default_nettype wire

// >>> tb/thermal_alarm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_assertions
  import thermal_alarm_pkg::*;
#(
  parameter int BASE_CYCLES = 10,
  parameter int EXTRA_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Conversion and alarms
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire logic conv_cancel,
  input wire logic warning_alarm_oe,
  input wire logic overheat_shutdown_output_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  int gap_r;
  logic seen_r;
  logic long_r;
  always_ff @(posedge clk_sys) begin
    gap_r <= (!reset_n || conv_start) ? 0 : gap_r + 1;
  end
  always_ff @(posedge clk_sys) begin
    seen_r <= reset_n && (seen_r || conv_start);
  end
  always_ff @(posedge clk_sys) begin
    if (gap_r == 0) begin
      long_r <= conv_cancel;
    end
  end
  AST_CANCEL_CH1: assert property (conv_cancel |-> conv_chan == CH_REMOTE1)
    else $error("cancellation on a channel other than 1");
  AST_CONV_SPACING: assert property (conv_start && seen_r |->
    gap_r == (long_r ? BASE_CYCLES + EXTRA_CYCLES + 2 : BASE_CYCLES + 2))
    else $error("conversion spacing off");
  AST_CFG3_RESERVED: assert property (reg_rd && reg_addr == ADDR_CONFIG3 |=>
    (reg_rdata & ~OVERHEAT_CH_MASK) == 8'h00) else $error("mask reserved bit set");
  AST_STATUS1_TOP: assert property (reg_rd && reg_addr == ADDR_STATUS1 |=> !reg_rdata[7])
    else $error("warning status bit 7 set");
  AST_STATUS2_RESERVED: assert property (reg_rd && reg_addr == ADDR_STATUS2 |=>
    (reg_rdata & 8'hC6) == 8'h00) else $error("overheat status reserved bit set");
  AST_MASK_ALL: assert property (reg_wr && reg_addr == ADDR_CONFIG3 &&
    (reg_wdata & OVERHEAT_CH_MASK) == OVERHEAT_CH_MASK |-> ##2 !overheat_shutdown_output_oe)
    else $error("masked overheat still drives");
  // The overheat pin may only fall, and the warning pin only rise, near a conversion end or any register write, never on a status read.
  AST_OVERHEAT_HOLD: assert property ($fell(overheat_shutdown_output_oe) |->
    conv_start || $past(conv_start) || $past(conv_start, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("overheat released outside a conversion end");
  AST_WARN_RISE: assert property ($rose(warning_alarm_oe) |->
    conv_start || $past(conv_start) || $past(conv_start, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("warning raised outside a conversion end");
endmodule
bind thermal_alarm_status_mask thermal_alarm_assertions #(.BASE_CYCLES(BASE_CYCLES),
  .EXTRA_CYCLES(EXTRA_CYCLES)) chk_u (.clk_sys, .reset_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .conv_start, .conv_chan, .conv_cancel, .warning_alarm_oe,
  .overheat_shutdown_output_oe);
`default_nettype wire

// >>> tb/thermal_alarm_status_mask_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_status_mask_tb_top
  import thermal_alarm_pkg::*;
;
  localparam int BASE = 10;
  localparam int EXTRA = 20;
  localparam int ROUND = 200;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, meas_temp, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, meas_fault;
  logic conv_start, conv_cancel, warn_oe, ovh_oe, warn_o, ovh_o;
  logic [2:0] conv_chan;
  logic [55:0] temps = {7{8'h14}};
  logic [31:0] seed = 32'h31;
  logic [7:0] exp_q[$], msk_q[$];
  int miscompares = 0, compares = 0, ch3_starts = 0, long_starts = 0;

  thermal_alarm_status_mask #(.BASE_CYCLES(BASE), .EXTRA_CYCLES(EXTRA)) dut_u (.clk_sys,
    .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .conv_start, .conv_chan,
    .conv_cancel, .meas_temp, .meas_fault, .warn_limits({7{8'h28}}),
    .overheat_limits({6{8'h32}}), .warning_alarm_o(warn_o), .warning_alarm_oe(warn_oe),
    .overheat_shutdown_output_o(ovh_o), .overheat_shutdown_output_oe(ovh_oe));
  conv_engine_model #(.BASE_CYCLES(BASE), .EXTRA_CYCLES(EXTRA)) eng_u (.clk_sys, .conv_start,
    .conv_chan, .conv_cancel, .temps, .faults(7'h08), .meas_temp, .meas_fault);

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A read queues its expectation; the monitor below compares when the data lands.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] v,
                     input logic [7:0] m);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = wr;
    reg_rd = !wr;
    if (!wr) begin
      exp_q.push_back(v);
      msk_q.push_back(m);
    end
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
  end

  // Pulses are counted mid-cycle, away from the edge that launches them.
  always @(negedge clk_sys) begin
    if (conv_start && conv_chan == 3'h3) ch3_starts++;
    if (conv_start && conv_cancel) long_starts++;
  end

  always @(negedge clk_sys) begin
    if (rd_d) begin
      check_byte(reg_rdata & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    idle(12);
    reset_n = 1'b1;
    for (int a = 'h40; a <= 'h47; a++) acc(0, a[7:0], 8'h00, 8'hFF);
    repeat (4) begin
      d = xrand();
      acc(1, ADDR_CONFIG3, d, 8'h00);
      acc(0, ADDR_CONFIG3, d & OVERHEAT_CH_MASK, 8'hFF);
      acc(1, ADDR_CONFIG2, d, 8'h00);
      acc(0, ADDR_CONFIG2, d & CONFIG2_WMASK, 8'hFF);
      acc(1, ADDR_STATUS1, d, 8'h00);
      acc(0, ADDR_STATUS1, 8'h00, 8'hFF);
    end
    acc(1, ADDR_CONFIG3, 8'h00, 8'h00);
    acc(1, ADDR_CONFIG2, 8'h04, 8'h00);
    temps = {7{8'h33}};
    idle(ROUND);
    acc(0, ADDR_STATUS1, 8'h7B, 8'hFF);
    acc(0, ADDR_STATUS2, 8'h39, 8'hFF);
    acc(0, ADDR_STATUS3, 8'h08, 8'hFF);
    idle(2);
    check_pin(ovh_oe, 1'b1);
    check_pin(ovh_o, 1'b0);
    // The status read cleared the flags; the next conversion end must raise the pin again.
    idle(16);
    check_pin(warn_oe, 1'b1);
    check_pin(warn_o, 1'b0);
    acc(1, ADDR_CONFIG3, 8'h39, 8'h00);
    idle(3);
    check_pin(ovh_oe, 1'b0);
    acc(1, ADDR_CONFIG3, 8'h00, 8'h00);
    acc(1, ADDR_CONFIG2, 8'h7F, 8'h00);
    idle(3);
    check_pin(warn_oe, 1'b0);
    acc(1, ADDR_CONFIG2, 8'h04, 8'h00);
    temps = {7{8'h2F}};
    acc(0, ADDR_STATUS2, 8'h00, 8'h00);
    idle(ROUND);
    acc(0, ADDR_STATUS2, 8'h39, 8'hFF);
    temps = {7{8'h2D}};
    idle(ROUND);
    acc(0, ADDR_STATUS2, 8'h00, 8'h00);
    idle(ROUND);
    acc(0, ADDR_STATUS2, 8'h00, 8'hFF);
    acc(0, ADDR_STATUS1, 8'h7B, 8'hFF);
    check_pin(ovh_oe, 1'b0);
    temps = {7{8'h14}};
    idle(ROUND);
    acc(0, ADDR_STATUS1, 8'h00, 8'h00);
    idle(ROUND);
    acc(0, ADDR_STATUS1, 8'h00, 8'hFF);
    check_pin(warn_oe, 1'b0);
    acc(1, ADDR_CONFIG1, 8'h08, 8'h00);
    idle(ROUND);
    acc(0, ADDR_CONFIG1, 8'h08, 8'hFF);
    check_byte({7'h00, long_starts != 0}, 8'h01);
    check_byte(ch3_starts[7:0], 8'h01);
    idle(4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
